// ==== hdl/tsa_pkg.sv ====
// shared constants for the temperature sensor alert and register core
package tsa_pkg;
  // register pointer values
  localparam logic [7:0] PTR_CAPABILITY = 8'h00;
  localparam logic [7:0] PTR_CONFIG = 8'h01;
  localparam logic [7:0] PTR_UPPER = 8'h02;
  localparam logic [7:0] PTR_LOWER = 8'h03;
  localparam logic [7:0] PTR_CRITICAL = 8'h04;
  localparam logic [7:0] PTR_TEMPERATURE = 8'h05;
  localparam logic [7:0] PTR_MAKER_ID = 8'h06;
  localparam logic [7:0] PTR_PART_ID = 8'h07;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // fixed capability word, bit fields shown for reference
  localparam logic [15:0] CAPABILITY_WORD = 16'h007F;
  localparam int CAP_INTERRUPT_CAPABLE_FLAG = 0;
  localparam int CAP_ACCURACY_FLAG = 1;
  localparam int CAP_NEG_RANGE_FLAG = 2;
  localparam int CAP_RESOLUTION_FIELD_LO = 3;
  localparam int CAP_RESERVED_BITS_ONE = 5;
  localparam int CAP_BUS_TIMEOUT_FLAG = 6;
  localparam int CAP_SLEEP_ALERT_BEHAVIOUR = 7;
  // sensor_configuration field positions
  localparam int CFG_ALERT_BEHAVIOUR_SELECT = 0;
  localparam int CFG_ALERT_POLARITY = 1;
  localparam int CFG_CRITICAL_ONLY = 2;
  localparam int CFG_ALERT_ENABLE = 3;
  localparam int CFG_ALERT_STATUS = 4;
  localparam int CFG_ALERT_CLEAR_BIT = 5;
  localparam int CFG_WINDOW_LOCK = 6;
  localparam int CFG_CRITICAL_LOCK = 7;
  localparam int CFG_SLEEP_CONTROL = 8;
  localparam int CFG_HYSTERESIS_SELECT_LO = 9;
  localparam int CFG_HYSTERESIS_SELECT_HI = 10;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  // temperature word layout
  localparam int TEMP_FLAG_CRITICAL = 15;
  localparam int TEMP_FLAG_UPPER = 14;
  localparam int TEMP_FLAG_LOWER = 13;
  localparam int TEMP_VALUE_HI = 12;
  // hysteresis amounts in 1/16 degree steps: none, 1.5, 3.0, 6.0
  localparam logic [7:0] HYST_NONE = 8'h00;
  localparam logic [7:0] HYST_1P5 = 8'h18;
  localparam logic [7:0] HYST_3P0 = 8'h30;
  localparam logic [7:0] HYST_6P0 = 8'h60;
  // serial address: type code and fields
  localparam logic [3:0] BUS_TYPE_CODE = 4'h3;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // system clock samples the bus clock must stand high before a start or stop counts
  localparam logic [2:0] SCL_SETTLE_CYCLES = 3'h3;
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SAMPLES_PER_SECOND = 16;
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLES_PER_SECOND;
  localparam int BUS_TIMEOUT_MIN_MS = 25;
  localparam int BUS_TIMEOUT_MAX_MS = 35;
  localparam int BUS_TIMEOUT_CYCLES =
    (BUS_TIMEOUT_MIN_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // identity words, values are arbitrary
  localparam logic [15:0] MAKER_ID_DEFAULT = 16'hA5C3;
  localparam logic [15:0] PART_ID_DEFAULT = 16'h5E01;
  typedef enum logic [2:0] {
    TSA_ADDR, TSA_PTR, TSA_WR_HI, TSA_WR_LO, TSA_READ, TSA_IGNORE
  } tsa_link_e;
endpackage : tsa_pkg

// ==== hdl/tsa_core.sv ====
// temperature sensor alert logic, register bank and two-wire slave
`timescale 1ns/10ps
`default_nettype none
module tsa_core
  import tsa_pkg::*;
#(
  parameter int SAMPLE_PERIOD = SAMPLE_CYCLES,
  parameter int TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES,
  parameter logic [15:0] MAKER_ID = MAKER_ID_DEFAULT,
  parameter logic [15:0] PART_ID = PART_ID_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] addr_sel,
  input wire logic [11:0] conv_code,
  output logic alert_out,
  output logic alert_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic above_hyst(input logic was_above, input logic [12:0] t,
                                      input logic [12:0] lim, input logic [7:0] h);
    logic signed [14:0] ts;
    logic signed [14:0] ls;
    ts = 15'(signed'(t));
    ls = 15'(signed'(lim));
    // once above, only a drop below limit minus hysteresis clears it
    if (was_above) begin
      above_hyst = ts >= (ls - signed'(15'(h)));
    end else begin
      above_hyst = ts > ls;
    end
  endfunction : above_hyst

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus condition detection (system clock)
  logic scl_m, scl_s, sda_m, sda_s, sda_d;
  logic [2:0] addr_m, addr_s;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      addr_m <= 3'h0;
      addr_s <= 3'h0;
    end else begin
      scl_m <= scl;
      scl_s <= scl_m;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      addr_m <= addr_sel;
      addr_s <= addr_m;
    end
  end

  logic start_evt, stop_evt, tout_hit, scl_settled;
  logic [20:0] tout_cnt;
  logic [2:0] scl_high_run;
  // a fast bus clock is sampled high for two cycles at most, so a data change
  // within a bit never passes for a start or stop
  assign scl_settled = scl_s && scl_high_run == SCL_SETTLE_CYCLES;
  assign start_evt = scl_settled && sda_d && !sda_s;
  assign stop_evt = scl_settled && !sda_d && sda_s;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_high_run <= 3'h0;
    end else if (!scl_s) begin
      scl_high_run <= 3'h0;
    end else if (scl_high_run != SCL_SETTLE_CYCLES) begin
      scl_high_run <= scl_high_run + 3'h1;
    end
  end
  assign tout_hit = tout_cnt == 21'(TIMEOUT_CYCLES - 1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tout_cnt <= 21'h0;
    end else if (scl_s) begin
      tout_cnt <= 21'h0;
    end else if (!tout_hit) begin
      tout_cnt <= tout_cnt + 21'h1;
    end
  end

  // link side is held in reset between frames, pulsed at each start
  logic link_rst_b, start_d;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link_rst_b <= 1'b0;
      start_d <= 1'b0;
    end else begin
      start_d <= start_evt;
      if (start_evt || stop_evt || tout_hit) begin
        link_rst_b <= 1'b0;
      end else if (start_d) begin
        link_rst_b <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side: shifts on the master clock
  tsa_link_e lstate;
  logic [3:0] bit_cnt;
  logic [6:0] shreg;
  logic ack_due, rd_hi;
  logic [7:0] rx_byte;
  logic [15:0] snap;
  logic [7:0] tx_byte;
  assign rx_byte = {shreg, sda_in};
  assign tx_byte = rd_hi ? snap[15:8] : snap[7:0];

  always_ff @(posedge scl or negedge link_rst_b) begin
    if (!link_rst_b) begin
      lstate <= TSA_ADDR;
      bit_cnt <= 4'h0;
      shreg <= 7'h0;
      ack_due <= 1'b0;
      rd_hi <= 1'b1;
    end else begin
      bit_cnt <= (bit_cnt == BIT_ACK) ? 4'h0 : bit_cnt + 4'h1;
      if (bit_cnt < BIT_LAST) begin
        shreg <= rx_byte[6:0];
      end
      if (bit_cnt == BIT_LAST) begin
        ack_due <= 1'b1;
        case (lstate)
          TSA_ADDR: begin
            if (rx_byte[7:4] == BUS_TYPE_CODE && rx_byte[3:1] == addr_s) begin
              lstate <= rx_byte[0] ? TSA_READ : TSA_PTR;
              rd_hi <= 1'b1;
            end else begin
              lstate <= TSA_IGNORE;
              ack_due <= 1'b0;
            end
          end
          TSA_PTR: lstate <= TSA_WR_HI;
          TSA_WR_HI: lstate <= TSA_WR_LO;
          TSA_WR_LO: lstate <= TSA_WR_HI;
          default: ack_due <= 1'b0;
        endcase
      end else if (bit_cnt == BIT_ACK) begin
        ack_due <= 1'b0;
        if (lstate == TSA_READ && !ack_due) begin
          if (sda_in) begin
            lstate <= TSA_IGNORE;
          end else begin
            rd_hi <= !rd_hi;
          end
        end
      end
    end
  end

  // written bytes and their event toggle live through link resets
  logic [7:0] ptr_byte, data_hi, data_lo;
  logic ev_tog, ev_is_data;
  always_ff @(posedge scl or negedge rst_b) begin
    if (!rst_b) begin
      ptr_byte <= PTR_RESET;
      data_hi <= 8'h00;
      data_lo <= 8'h00;
      ev_tog <= 1'b0;
      ev_is_data <= 1'b0;
    end else if (link_rst_b && bit_cnt == BIT_LAST) begin
      case (lstate)
        TSA_PTR: begin
          ptr_byte <= rx_byte;
          ev_is_data <= 1'b0;
          ev_tog <= !ev_tog;
        end
        TSA_WR_HI: data_hi <= rx_byte;
        TSA_WR_LO: begin
          data_lo <= rx_byte;
          ev_is_data <= 1'b1;
          ev_tog <= !ev_tog;
        end
        default: ev_tog <= ev_tog;
      endcase
    end
  end

  // data line changes on the falling clock edge, low or released only
  always_ff @(negedge scl or negedge link_rst_b) begin
    if (!link_rst_b) begin
      sda_oe <= 1'b0;
    end else if (bit_cnt == BIT_ACK) begin
      sda_oe <= ack_due;
    end else if (lstate == TSA_READ) begin
      sda_oe <= !tx_byte[~bit_cnt[2:0]];
    end else begin
      sda_oe <= 1'b0;
    end
  end

  logic drive_low;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_low <= 1'b0;
    end else begin
      drive_low <= 1'b0;
    end
  end
  assign sda_out = drive_low;
  assign alert_out = drive_low;

  ////////////////////////////////////////////////////////////////////////////
  // write events into the register bank
  logic ev_m, ev_s, ev_d, ev_pulse;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_m <= 1'b0;
      ev_s <= 1'b0;
      ev_d <= 1'b0;
    end else begin
      ev_m <= ev_tog;
      ev_s <= ev_m;
      ev_d <= ev_s;
    end
  end
  assign ev_pulse = ev_s != ev_d;

  logic [7:0] pointer;
  logic wr_en;
  logic [15:0] wr_data;
  assign wr_en = ev_pulse && ev_is_data;
  assign wr_data = {data_hi, data_lo};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pointer <= PTR_RESET;
    end else if (ev_pulse && !ev_is_data) begin
      pointer <= ptr_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration and limit registers
  logic behaviour_int, alert_pol, crit_only, alert_en, win_lock, crit_lock;
  logic sleep_control;
  logic [1:0] hysteresis_select;
  logic [15:0] upper_lim, lower_lim, crit_lim;
  logic cfg_wr, clear_req, locked;
  assign cfg_wr = wr_en && pointer == PTR_CONFIG;
  assign clear_req = cfg_wr && wr_data[CFG_ALERT_CLEAR_BIT];
  assign locked = win_lock || crit_lock;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      behaviour_int <= CONFIG_RESET[CFG_ALERT_BEHAVIOUR_SELECT];
      alert_pol <= CONFIG_RESET[CFG_ALERT_POLARITY];
      crit_only <= CONFIG_RESET[CFG_CRITICAL_ONLY];
      alert_en <= CONFIG_RESET[CFG_ALERT_ENABLE];
      win_lock <= CONFIG_RESET[CFG_WINDOW_LOCK];
      crit_lock <= CONFIG_RESET[CFG_CRITICAL_LOCK];
      sleep_control <= CONFIG_RESET[CFG_SLEEP_CONTROL];
      hysteresis_select <= CONFIG_RESET[CFG_HYSTERESIS_SELECT_HI -: 2];
    end else if (cfg_wr) begin
      behaviour_int <= wr_data[CFG_ALERT_BEHAVIOUR_SELECT];
      alert_pol <= wr_data[CFG_ALERT_POLARITY];
      crit_only <= wr_data[CFG_CRITICAL_ONLY];
      alert_en <= wr_data[CFG_ALERT_ENABLE];
      win_lock <= wr_data[CFG_WINDOW_LOCK];
      crit_lock <= wr_data[CFG_CRITICAL_LOCK];
      // locks forbid entering shutdown or changing hysteresis
      if (!locked || !wr_data[CFG_SLEEP_CONTROL]) begin
        sleep_control <= wr_data[CFG_SLEEP_CONTROL];
      end
      if (!locked) begin
        hysteresis_select <= wr_data[CFG_HYSTERESIS_SELECT_HI:CFG_HYSTERESIS_SELECT_LO];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      upper_lim <= LIMIT_RESET;
      lower_lim <= LIMIT_RESET;
      crit_lim <= LIMIT_RESET;
    end else if (wr_en) begin
      // read-only and reserved targets fall through unchanged
      case (pointer)
        PTR_UPPER: if (!win_lock) upper_lim <= wr_data;
        PTR_LOWER: if (!win_lock) lower_lim <= wr_data;
        PTR_CRITICAL: if (!crit_lock) crit_lim <= wr_data;
        default: upper_lim <= upper_lim;
      endcase
    end
  end

  logic [7:0] hyst;
  always_comb begin
    case (hysteresis_select)
      2'b01: hyst = HYST_1P5;
      2'b10: hyst = HYST_3P0;
      2'b11: hyst = HYST_6P0;
      default: hyst = HYST_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sampling and limit flags
  logic [21:0] sample_cnt;
  logic sample_tick;
  assign sample_tick = !sleep_control && sample_cnt == 22'(SAMPLE_PERIOD - 1);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_cnt <= 22'h0;
    end else if (sleep_control) begin
      sample_cnt <= sample_cnt;
    end else if (sample_tick) begin
      sample_cnt <= 22'h0;
    end else begin
      sample_cnt <= sample_cnt + 22'h1;
    end
  end

  logic [12:0] temp_val, next_temp;
  logic flag_upper, flag_lower, flag_crit;
  logic next_upper, next_lower, next_crit;
  assign next_temp = {conv_code, 1'b0};
  assign next_upper = above_hyst(flag_upper, next_temp, upper_lim[12:0], hyst);
  assign next_lower = !above_hyst(!flag_lower, next_temp, lower_lim[12:0], hyst);
  assign next_crit = above_hyst(flag_crit, next_temp, crit_lim[12:0], hyst);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      temp_val <= 13'h0;
      flag_upper <= 1'b0;
      flag_lower <= 1'b0;
      flag_crit <= 1'b0;
    end else if (sample_tick) begin
      temp_val <= next_temp;
      flag_upper <= next_upper;
      flag_lower <= next_lower;
      flag_crit <= next_crit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alert behaviour
  logic int_latch, window_edge, alert_active, next_active;
  assign window_edge = sample_tick && ((next_upper || next_lower) != (flag_upper || flag_lower));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_latch <= 1'b0;
    end else if (window_edge) begin
      int_latch <= 1'b1;
    end else if (clear_req) begin
      int_latch <= 1'b0;
    end
  end

  always_comb begin
    if (crit_only) begin
      next_active = flag_crit;
    end else if (behaviour_int) begin
      next_active = int_latch || flag_crit;
    end else begin
      next_active = flag_upper || flag_lower || flag_crit;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alert_active <= 1'b0;
      alert_oe <= 1'b0;
    end else if (!sleep_control) begin
      alert_active <= next_active;
      alert_oe <= alert_en && (next_active != alert_pol);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data for the link, frozen while a frame is running
  logic [15:0] rd_word, cfg_word;
  always_comb begin
    cfg_word = 16'h0000;
    cfg_word[CFG_ALERT_BEHAVIOUR_SELECT] = behaviour_int;
    cfg_word[CFG_ALERT_POLARITY] = alert_pol;
    cfg_word[CFG_CRITICAL_ONLY] = crit_only;
    cfg_word[CFG_ALERT_ENABLE] = alert_en;
    cfg_word[CFG_ALERT_STATUS] = alert_active;
    cfg_word[CFG_WINDOW_LOCK] = win_lock;
    cfg_word[CFG_CRITICAL_LOCK] = crit_lock;
    cfg_word[CFG_SLEEP_CONTROL] = sleep_control;
    cfg_word[CFG_HYSTERESIS_SELECT_HI:CFG_HYSTERESIS_SELECT_LO] = hysteresis_select;
  end

  always_comb begin
    case (pointer)
      PTR_CAPABILITY: rd_word = CAPABILITY_WORD;
      PTR_CONFIG: rd_word = cfg_word;
      PTR_UPPER: rd_word = upper_lim;
      PTR_LOWER: rd_word = lower_lim;
      PTR_CRITICAL: rd_word = crit_lim;
      PTR_TEMPERATURE: rd_word = {flag_crit, flag_upper, flag_lower, temp_val};
      PTR_MAKER_ID: rd_word = MAKER_ID;
      PTR_PART_ID: rd_word = PART_ID;
      default: rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      snap <= CAPABILITY_WORD;
    end else if (!link_rst_b || start_evt) begin
      snap <= rd_word;
    end
  end

endmodule : tsa_core
`default_nettype wire

// ==== verification/tsa_core_monitor.sv ====
// checker on the ports of the sensor core
`timescale 1ns/10ps
`default_nettype none
module tsa_core_monitor #(
  parameter int TIMEOUT_CYCLES = 300
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [2:0] addr_sel,
  input wire logic [11:0] conv_code,
  input wire logic alert_out,
  input wire logic alert_oe
);
  logic [19:0] low_cnt;
  logic [3:0] drv_run;
  logic oe_at_rise;
  ////////////////////////////////////////////////////////////////////////////
  // clock cycles with the bus clock low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) low_cnt <= '0;
    else low_cnt <= scl ? 20'h0 : low_cnt + 20'h1;
  end
  // bus clock periods that the device kept the data line pulled
  always_ff @(negedge scl or negedge rst_b) begin
    if (!rst_b) drv_run <= '0;
    else drv_run <= sda_oe ? drv_run + 4'h1 : 4'h0;
  end
  always_ff @(posedge scl or negedge rst_b) begin
    if (!rst_b) oe_at_rise <= 1'b0;
    else oe_at_rise <= sda_oe;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_sda_low_only;
    @(posedge clk) disable iff (!rst_b) sda_out == 1'b0;
  endproperty
  a_sda_low_only: assert property (p_sda_low_only) else $error("data driven high");
  property p_alert_low_only;
    @(posedge clk) disable iff (!rst_b) alert_out == 1'b0;
  endproperty
  a_alert_low_only: assert property (p_alert_low_only) else $error("alert driven high");
  property p_reset_quiet;
    @(posedge clk) disable iff (!rst_b) $rose(rst_b) |-> !sda_oe && !alert_oe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("pins active after reset");
  property p_timeout;
    @(posedge clk) disable iff (!rst_b) low_cnt > TIMEOUT_CYCLES + 8 |-> !sda_oe;
  endproperty
  a_timeout: assert property (p_timeout) else $error("data held past timeout");
  property p_no_early;
    @(posedge clk) disable iff (!rst_b)
      $fell(sda_oe) && low_cnt > 20'd3 |-> low_cnt >= TIMEOUT_CYCLES;
  endproperty
  a_no_early: assert property (p_no_early) else $error("timeout too early");
  property p_stable_high;
    @(negedge scl) disable iff (!rst_b) sda_oe == oe_at_rise;
  endproperty
  a_stable_high: assert property (p_stable_high) else $error("data moved, clock high");
  property p_idle_released;
    @(posedge clk) disable iff (!rst_b) scl [*3] |-> !sda_oe;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("data held while idle");
  property p_drive_run;
    @(negedge scl) disable iff (!rst_b) drv_run <= 4'd9;
  endproperty
  a_drive_run: assert property (p_drive_run) else $error("data held over a byte");
  c_alert: cover property (@(posedge clk) disable iff (!rst_b) $rose(alert_oe));
  c_timeout: cover property (@(posedge clk) disable iff (!rst_b)
    $fell(sda_oe) && low_cnt > TIMEOUT_CYCLES);
  c_run9: cover property (@(negedge scl) disable iff (!rst_b) drv_run == 4'd9);
endmodule : tsa_core_monitor
`default_nettype wire

// ==== verification/tsa_bus_master.sv ====
// two-wire bus master model: makes the bus clock, only pulls data low
`timescale 1ns/10ps
`default_nettype none
module tsa_bus_master (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // one 30 ns bit, data set while clock low, sampled late in high phase
  task automatic bitx(input logic o, output logic i);
    #2 sda_pull = ~o;
    #13 scl = 1'b1;
    #14 i = sda;
    #1 scl = 1'b0;
  endtask : bitx
  // byte most significant bit first, then the acknowledge bit
  task automatic xfer(input logic [7:0] o, input logic ack_o, output logic [7:0] i,
      output logic ack_i);
    logic b;
    for (int k = 7; k >= 0; k--) begin
      bitx(o[k], b);
      i[k] = b;
    end
    bitx(ack_o, ack_i);
  endtask : xfer
  // clock stays high after the start so the device can release its link side
  task automatic start();
    #2 sda_pull = 1'b0;
    #13 scl = 1'b1;
    #100 sda_pull = 1'b1;
    #100 scl = 1'b0;
  endtask : start
  // clock stands still high after the frame
  task automatic stop();
    #2 sda_pull = 1'b1;
    #13 scl = 1'b1;
    #100 sda_pull = 1'b0;
    #100;
  endtask : stop
endmodule : tsa_bus_master
`default_nettype wire

// ==== verification/tsa_core_tb.sv ====
// testbench of the sensor core against a bus master model
`timescale 1ns/10ps
`default_nettype none
module tsa_core_tb;
  import tsa_pkg::*;
  localparam int SP = 200;
  localparam int TO = 300;
  // identity values are arbitrary
  localparam logic [15:0] MID = 16'h1A2B;
  localparam logic [15:0] PID = 16'h2C3D;
  localparam logic [2:0] ASEL = 3'h5;
  logic clk, rst_b, scl, sda_pull, sda_out, sda_oe, alert_out, alert_oe;
  logic [2:0] addr_sel;
  logic [11:0] conv_code;
  wire logic sda = !(sda_oe || sda_pull);
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  tsa_core #(.SAMPLE_PERIOD(SP), .TIMEOUT_CYCLES(TO), .MAKER_ID(MID), .PART_ID(PID)) tsa_core_i (
    .clk(clk), .rst_b(rst_b), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_sel(addr_sel), .conv_code(conv_code), .alert_out(alert_out), .alert_oe(alert_oe));
  tsa_bus_master tsa_bus_master_i (.scl(scl), .sda_pull(sda_pull), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 40000) begin
      err_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // writes never aim at reserved pointers
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    logic [7:0] x;
    logic [3:0] a;
    tsa_bus_master_i.start();
    tsa_bus_master_i.xfer({BUS_TYPE_CODE, ASEL, 1'b0}, 1'b1, x, a[3]);
    tsa_bus_master_i.xfer(p, 1'b1, x, a[2]);
    tsa_bus_master_i.xfer(d[15:8], 1'b1, x, a[1]);
    tsa_bus_master_i.xfer(d[7:0], 1'b1, x, a[0]);
    tsa_bus_master_i.stop();
    check("write ack", {12'h0, a}, 16'h0000);
  endtask : wr
  task automatic rd(input logic [7:0] p, input logic np, input logic [15:0] e);
    logic [7:0] hi, lo, x;
    logic a0, a1, a2, n;
    a0 = 1'b0;
    a1 = 1'b0;
    if (!np) begin
      tsa_bus_master_i.start();
      tsa_bus_master_i.xfer({BUS_TYPE_CODE, ASEL, 1'b0}, 1'b1, x, a0);
      tsa_bus_master_i.xfer(p, 1'b1, x, a1);
    end
    tsa_bus_master_i.start();
    tsa_bus_master_i.xfer({BUS_TYPE_CODE, ASEL, 1'b1}, 1'b1, x, a2);
    tsa_bus_master_i.xfer(8'hFF, 1'b0, hi, n);
    tsa_bus_master_i.xfer(8'hFF, 1'b1, lo, n);
    tsa_bus_master_i.stop();
    check("read ack", {13'h0, a0, a1, a2}, 16'h0000);
    check("read data", {hi, lo}, e);
  endtask : rd
  task automatic set_temp(input logic [11:0] c);
    @(posedge clk);
    conv_code <= c;
    repeat (2 * SP + 4) @(posedge clk);
  endtask : set_temp
  task automatic al(input logic e);
    repeat (2) @(posedge clk);
    #1 check("alert", {15'h0, alert_oe}, {15'h0, e});
  endtask : al
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [15:0] tab [8];
    tab = '{16'h007F, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, MID, PID};
    rd(8'h00, 1'b1, 16'h007F);
    rd(8'h00, 1'b1, 16'h007F);
    for (int p = 0; p < 8; p++) begin
      rd(p[7:0], 1'b0, tab[p]);
    end
    wr(PTR_CAPABILITY, 16'hFFFF);
    wr(PTR_MAKER_ID, 16'h0000);
    rd(PTR_CAPABILITY, 1'b0, 16'h007F);
    rd(PTR_MAKER_ID, 1'b0, MID);
    wr(PTR_CONFIG, 16'h0020);
    rd(PTR_CONFIG, 1'b0, 16'h0000);
  endtask : t_regs
  task automatic t_addr();
    logic [7:0] x;
    logic n;
    for (int k = 0; k < 2; k++) begin
      tsa_bus_master_i.start();
      tsa_bus_master_i.xfer(k ? {4'h2, ASEL, 1'b1} : {BUS_TYPE_CODE, ASEL ^ 3'h1, 1'b1},
        1'b1, x, n);
      tsa_bus_master_i.stop();
      check("nack", {15'h0, n}, 16'h0001);
    end
  endtask : t_addr
  task automatic t_comp();
    logic [11:0] on_c [4];
    logic [11:0] off_c [4];
    on_c = '{12'h050, 12'h048, 12'h03C, 12'h024};
    off_c = '{12'h04C, 12'h03C, 12'h030, 12'h018};
    wr(PTR_UPPER, 16'h00A0);
    wr(PTR_CRITICAL, 16'h0200);
    for (int h = 0; h < 4; h++) begin
      wr(PTR_CONFIG, {5'h00, h[1:0], 9'h008});
      set_temp(12'h060);
      al(1'b1);
      set_temp(on_c[h]);
      al(1'b1);
      set_temp(off_c[h]);
      al(1'b0);
    end
  endtask : t_comp
  task automatic t_modes();
    wr(PTR_CONFIG, 16'h0229);
    set_temp(12'h060);
    al(1'b1);
    wr(PTR_CONFIG, 16'h0229);
    al(1'b0);
    set_temp(12'h060);
    al(1'b0);
    set_temp(12'h018);
    al(1'b1);
    wr(PTR_CONFIG, 16'h0229);
    al(1'b0);
    wr(PTR_CONFIG, 16'h020C);
    set_temp(12'h110);
    al(1'b1);
    set_temp(12'h0F8);
    al(1'b1);
    set_temp(12'h0E8);
    al(1'b0);
  endtask : t_modes
  task automatic t_sleep();
    wr(PTR_CONFIG, 16'h0208);
    set_temp(12'h060);
    al(1'b1);
    wr(PTR_CONFIG, 16'h0308);
    set_temp(12'h040);
    al(1'b1);
    rd(PTR_TEMPERATURE, 1'b0, 16'h40C0);
    wr(PTR_CONFIG, 16'h0208);
    set_temp(12'h040);
    al(1'b0);
    wr(PTR_CONFIG, 16'h020A);
    al(1'b1);
  endtask : t_sleep
  task automatic t_timeout();
    logic [7:0] x;
    logic n;
    tsa_bus_master_i.start();
    tsa_bus_master_i.xfer({BUS_TYPE_CODE, ASEL, 1'b1}, 1'b1, x, n);
    #10 check("driving", {15'h0, sda_oe}, 16'h0001);
    repeat (TO + 20) @(posedge clk);
    #1 check("released", {15'h0, sda_oe}, 16'h0000);
    tsa_bus_master_i.stop();
    rd(PTR_CAPABILITY, 1'b0, 16'h007F);
  endtask : t_timeout
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    addr_sel = ASEL;
    conv_code = 12'h000;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_addr();
    set_temp(12'hFF0);
    rd(PTR_TEMPERATURE, 1'b0, 16'h3FE0);
    t_comp();
    t_modes();
    t_sleep();
    t_timeout();
    end_of_test();
  end
endmodule : tsa_core_tb
bind tsa_core tsa_core_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) tsa_core_monitor_i (
  .clk(clk), .rst_b(rst_b), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .addr_sel(addr_sel), .conv_code(conv_code), .alert_out(alert_out), .alert_oe(alert_oe));
`default_nettype wire
